// >>> hw/pl_ctrl_pkg.sv
// Package: register map, reset values and carrier types of the line controller
package pl_ctrl_pkg;

  // ************************************************************
  // Register offsets
  // ************************************************************
  localparam logic [7:0] OFF_PIN_CTRL_ENABLE = 8'h00;
  localparam logic [7:0] OFF_PIN_CTRL_DISABLE = 8'h04;
  localparam logic [7:0] OFF_PIN_CTRL_STATUS = 8'h08;
  localparam logic [7:0] OFF_OUT_ENABLE = 8'h10;
  localparam logic [7:0] OFF_OUT_DISABLE = 8'h14;
  localparam logic [7:0] OFF_OUT_STATUS = 8'h18;
  localparam logic [7:0] OFF_FILTER_ENABLE = 8'h20;
  localparam logic [7:0] OFF_FILTER_DISABLE = 8'h24;
  localparam logic [7:0] OFF_FILTER_STATUS = 8'h28;
  localparam logic [7:0] OFF_OUT_DATA_SET = 8'h30;
  localparam logic [7:0] OFF_OUT_DATA_CLEAR = 8'h34;
  localparam logic [7:0] OFF_OUT_DATA_STATE = 8'h38;
  localparam logic [7:0] OFF_PIN_LEVEL = 8'h3C;
  localparam logic [7:0] OFF_IRQ_ENABLE = 8'h40;
  localparam logic [7:0] OFF_IRQ_DISABLE = 8'h44;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h48;
  localparam logic [7:0] OFF_CHANGE_STATUS = 8'h4C;
  localparam logic [7:0] OFF_OPEN_DRAIN_ENABLE = 8'h50;
  localparam logic [7:0] OFF_OPEN_DRAIN_DISABLE = 8'h54;
  localparam logic [7:0] OFF_OPEN_DRAIN_STATUS = 8'h58;
  localparam logic [7:0] OFF_PULLUP_DISABLE = 8'h60;
  localparam logic [7:0] OFF_PULLUP_ENABLE = 8'h64;
  localparam logic [7:0] OFF_PULLUP_STATUS = 8'h68;
  localparam logic [7:0] OFF_PERIPH_A_SELECT = 8'h70;
  localparam logic [7:0] OFF_PERIPH_B_SELECT = 8'h74;
  localparam logic [7:0] OFF_PERIPH_SEL_STATUS = 8'h78;
  localparam logic [7:0] OFF_WRITE_MASK_ENABLE = 8'hA0;
  localparam logic [7:0] OFF_WRITE_MASK_DISABLE = 8'hA4;
  localparam logic [7:0] OFF_WRITE_MASK_STATUS = 8'hA8;

  // ************************************************************
  // Reset values
  // ************************************************************
  localparam logic [31:0] RST_ZERO = 32'h0000_0000;

  // ************************************************************
  // Carrier types
  // ************************************************************
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

  typedef struct packed {
    logic [31:0] out_data;
    logic [31:0] drive_en;
    logic [31:0] pullup_en;
  } pad_ctrl_t;

endpackage : pl_ctrl_pkg

// >>> hw/parallel_line_controller.sv
// Parallel line controller: register file, pad control, change detection
// Functional notes
// - Every register is a 32-bit word, bit n belongs to line n.
// - Writes to bits of unimplemented lines change nothing.
// - Bits of unimplemented lines always read as zero.
// - Lines without peripheral stay controller owned; ownership reads 1.
// - Writing 1 at 0x00 gives the line to the controller.
// - Writing 1 at 0x04 hands the line to its peripheral.
// - Ownership status at 0x08: 1 controller, 0 peripheral; reset parameter.
// - Writing 1 at 0x10 sets output status, enabling the driver of controller owned lines.
// - Filter enable, disable, status at 0x20/0x24/0x28; status resets zero.
// - Direct writes at 0x38 change only bits with write mask set.
// - Write mask set/clear at 0xA0/0xA4, status 0xA8 resets zero.
// - Pin level at 0x3C follows sampled lines; holds while clock stops.
// - Change status resets zero and ignores changes in the first cycle after reset.
// - Write 1 at 0x70 clears, at 0x74 sets peripheral select; status zero.
// - Open drain enable, disable, status 0x50/0x54/0x58; resets zero.
// - Pull-up disable 0x60 clears, enable 0x64 sets status 0x68.
// - Line change sets change bit; interrupt when bit and mask set.
// - Reading change status returns and clears all pending bits.
module parallel_line_controller
  import pl_ctrl_pkg::*;
#(
  parameter logic [31:0] IMPL_LINES = 32'hFFFF_FFFF,
  parameter logic [31:0] MUXED_LINES = 32'hFFFF_FFFF,
  parameter logic [31:0] OWN_RESET = 32'hFFFF_FFFF
)
(
  input wire logic sys_clk_in, // 250 MHz clock
  input wire logic sys_rst_in, // Synchronous reset, active high
  input wire logic [7:0] reg_addr_in, // Byte address
  input wire logic [31:0] reg_wdata_in, // Write data
  input wire logic reg_wr_in, // Write strobe
  input wire logic reg_rd_in, // Read strobe
  output logic [31:0] reg_rdata_out, // Read data, cycle after strobe
  input wire logic [31:0] pad_in, // Line levels from the pads
  output logic [31:0] pad_out, // Level driven on each line
  output logic [31:0] pad_oe_out, // Driver enable per line
  output logic [31:0] pad_pullup_out, // Pull-up enable per line
  input wire logic [31:0] periph_a_out_in, // Peripheral A output data
  input wire logic [31:0] periph_a_oe_in, // Peripheral A output enable
  input wire logic [31:0] periph_b_out_in, // Peripheral B output data
  input wire logic [31:0] periph_b_oe_in, // Peripheral B output enable
  output logic irq_out // Input change interrupt, level
);

  // ************************************************************
  // Register decode
  // ************************************************************
  reg_req_t req;
  assign req = '{addr: reg_addr_in, wdata: reg_wdata_in,
                 wr: reg_wr_in, rd: reg_rd_in};

  function automatic logic [31:0] wr_bits(input reg_req_t r,
                                          input logic [7:0] off,
                                          input logic [31:0] impl);
    wr_bits = (r.wr && r.addr == off) ? (r.wdata & impl) : RST_ZERO;
  endfunction : wr_bits

  wire logic [31:0] w_own_en = wr_bits(req, OFF_PIN_CTRL_ENABLE, IMPL_LINES);
  wire logic [31:0] w_own_dis =
    wr_bits(req, OFF_PIN_CTRL_DISABLE, IMPL_LINES & MUXED_LINES);
  wire logic [31:0] w_oe_en = wr_bits(req, OFF_OUT_ENABLE, IMPL_LINES);
  wire logic [31:0] w_oe_dis = wr_bits(req, OFF_OUT_DISABLE, IMPL_LINES);
  wire logic [31:0] w_flt_en = wr_bits(req, OFF_FILTER_ENABLE, IMPL_LINES);
  wire logic [31:0] w_flt_dis = wr_bits(req, OFF_FILTER_DISABLE, IMPL_LINES);
  wire logic [31:0] w_od_set = wr_bits(req, OFF_OUT_DATA_SET, IMPL_LINES);
  wire logic [31:0] w_od_clr = wr_bits(req, OFF_OUT_DATA_CLEAR, IMPL_LINES);
  wire logic [31:0] w_irq_en = wr_bits(req, OFF_IRQ_ENABLE, IMPL_LINES);
  wire logic [31:0] w_irq_dis = wr_bits(req, OFF_IRQ_DISABLE, IMPL_LINES);
  wire logic [31:0] w_md_en =
    wr_bits(req, OFF_OPEN_DRAIN_ENABLE, IMPL_LINES);
  wire logic [31:0] w_md_dis =
    wr_bits(req, OFF_OPEN_DRAIN_DISABLE, IMPL_LINES);
  wire logic [31:0] w_pu_dis = wr_bits(req, OFF_PULLUP_DISABLE, IMPL_LINES);
  wire logic [31:0] w_pu_en = wr_bits(req, OFF_PULLUP_ENABLE, IMPL_LINES);
  wire logic [31:0] w_sel_a = wr_bits(req, OFF_PERIPH_A_SELECT, IMPL_LINES);
  wire logic [31:0] w_sel_b = wr_bits(req, OFF_PERIPH_B_SELECT, IMPL_LINES);
  wire logic [31:0] w_wm_en =
    wr_bits(req, OFF_WRITE_MASK_ENABLE, IMPL_LINES);
  wire logic [31:0] w_wm_dis =
    wr_bits(req, OFF_WRITE_MASK_DISABLE, IMPL_LINES);
  wire logic w_ods_hit = req.wr && req.addr == OFF_OUT_DATA_STATE;

  // ************************************************************
  // State registers
  // ************************************************************
  logic [31:0] own_status;
  logic [31:0] oe_status;
  logic [31:0] flt_status;
  logic [31:0] od_status;
  logic [31:0] irq_mask;
  logic [31:0] chg_status;
  logic [31:0] md_status;
  logic [31:0] pu_status;
  logic [31:0] sel_status;
  logic [31:0] wm_status;
  logic [31:0] pin_sample;
  logic [31:0] pin_half;
  logic [31:0] pin_level;
  logic prev_valid;

  // Direct write only touches bits unmasked by the write mask
  wire logic [31:0] ods_wmask = w_ods_hit ? (wm_status & IMPL_LINES)
                                          : RST_ZERO;
  wire logic [31:0] next_od = (od_status & ~ods_wmask)
                            | (req.wdata & ods_wmask);

  // Filter: a level must stand two samples before it is taken
  wire logic [31:0] flt_level = (pin_sample & pin_half)
                              | (pin_level & (pin_sample | pin_half));
  wire logic [31:0] next_level =
    ((flt_status & flt_level) | (~flt_status & pin_sample)) & IMPL_LINES;
  wire logic [31:0] change = prev_valid ? (next_level ^ pin_level)
                                        : RST_ZERO;
  wire logic rd_chg = req.rd && req.addr == OFF_CHANGE_STATUS;
  // New change wins over the clear by read in the same cycle
  wire logic [31:0] next_chg = (rd_chg ? RST_ZERO : chg_status)
                             | change;

  always_ff @(posedge sys_clk_in)
  begin
    if (sys_rst_in)
    begin
      own_status <= OWN_RESET;
      oe_status <= RST_ZERO;
      flt_status <= RST_ZERO;
      od_status <= RST_ZERO;
      irq_mask <= RST_ZERO;
      chg_status <= RST_ZERO;
      md_status <= RST_ZERO;
      pu_status <= RST_ZERO;
      sel_status <= RST_ZERO;
      wm_status <= RST_ZERO;
      prev_valid <= 1'b0;
    end
    else
    begin
      own_status <= (own_status | w_own_en) & ~w_own_dis;
      oe_status <= (oe_status | w_oe_en) & ~w_oe_dis;
      flt_status <= (flt_status | w_flt_en) & ~w_flt_dis;
      od_status <= (next_od | w_od_set) & ~w_od_clr;
      irq_mask <= (irq_mask | w_irq_en) & ~w_irq_dis;
      chg_status <= next_chg;
      md_status <= (md_status | w_md_en) & ~w_md_dis;
      pu_status <= (pu_status | w_pu_en) & ~w_pu_dis;
      sel_status <= (sel_status | w_sel_b) & ~w_sel_a;
      wm_status <= (wm_status | w_wm_en) & ~w_wm_dis;
      prev_valid <= 1'b1;
    end
  end

  // Sampling runs on the clock, so levels freeze when it stops
  always_ff @(posedge sys_clk_in)
  begin
    pin_sample <= pad_in;
    pin_half <= pin_sample;
    pin_level <= next_level;
  end

  // ************************************************************
  // Pad muxing
  // ************************************************************
  wire logic [31:0] own_eff = (own_status | ~MUXED_LINES)
                            & IMPL_LINES;
  wire logic [31:0] p_data = (sel_status & periph_b_out_in)
                           | (~sel_status & periph_a_out_in);
  wire logic [31:0] p_oe = (sel_status & periph_b_oe_in)
                         | (~sel_status & periph_a_oe_in);
  wire logic [31:0] src_data = (own_eff & od_status) | (~own_eff & p_data);
  wire logic [31:0] src_oe = (own_eff & oe_status) | (~own_eff & p_oe);
  // Open drain lines only pull low
  wire logic [31:0] drv_oe = src_oe & ~(md_status & src_data);

  always_ff @(posedge sys_clk_in)
  begin
    if (sys_rst_in)
    begin
      pad_out <= RST_ZERO;
      pad_oe_out <= RST_ZERO;
      pad_pullup_out <= RST_ZERO;
    end
    else
    begin
      pad_out <= src_data & IMPL_LINES;
      pad_oe_out <= drv_oe & IMPL_LINES;
      pad_pullup_out <= pu_status & IMPL_LINES;
    end
  end

  assign irq_out = |(chg_status & irq_mask);

  // ************************************************************
  // Read path
  // ************************************************************
  logic [31:0] rd_mux;
  always_comb
  begin
    case (req.addr)
      OFF_PIN_CTRL_STATUS: rd_mux = own_eff;
      OFF_OUT_STATUS: rd_mux = oe_status;
      OFF_FILTER_STATUS: rd_mux = flt_status;
      OFF_OUT_DATA_STATE: rd_mux = od_status;
      OFF_PIN_LEVEL: rd_mux = pin_level;
      OFF_IRQ_MASK: rd_mux = irq_mask;
      OFF_CHANGE_STATUS: rd_mux = chg_status;
      OFF_OPEN_DRAIN_STATUS: rd_mux = md_status;
      OFF_PULLUP_STATUS: rd_mux = pu_status;
      OFF_PERIPH_SEL_STATUS: rd_mux = sel_status;
      OFF_WRITE_MASK_STATUS: rd_mux = wm_status;
      default: rd_mux = RST_ZERO;
    endcase
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (sys_rst_in)
      reg_rdata_out <= RST_ZERO;
    else if (req.rd)
      reg_rdata_out <= rd_mux & IMPL_LINES;
    else
      reg_rdata_out <= RST_ZERO;
  end

  // ************************************************************
  // Assertions
  // ************************************************************
  property p_set_clear;
    @(posedge sys_clk_in) disable iff (sys_rst_in)
    (|w_oe_en) |=> ((oe_status & $past(w_oe_en)) == $past(w_oe_en));
  endproperty
  a_set_clear: assert property (p_set_clear)
    else $error("out enable write did not set status");

  property p_own;
    @(posedge sys_clk_in) disable iff (sys_rst_in)
    (|w_own_dis) |=> ((own_status & $past(w_own_dis)) == 32'h0000_0000);
  endproperty
  a_own: assert property (p_own)
    else $error("ownership disable did not release line");

  property p_unmuxed;
    @(posedge sys_clk_in) disable iff (sys_rst_in)
    ((own_eff & IMPL_LINES & ~MUXED_LINES) == (IMPL_LINES & ~MUXED_LINES));
  endproperty
  a_unmuxed: assert property (p_unmuxed)
    else $error("line without peripheral not owned");

  property p_unimpl;
    @(posedge sys_clk_in) disable iff (sys_rst_in)
    ((reg_rdata_out & ~IMPL_LINES) == 32'h0000_0000);
  endproperty
  a_unimpl: assert property (p_unimpl)
    else $error("unimplemented bit read nonzero");

  property p_wmask;
    @(posedge sys_clk_in) disable iff (sys_rst_in)
    (w_ods_hit && !(|w_od_set) && !(|w_od_clr)) |=>
      (((od_status ^ $past(od_status)) & ~$past(wm_status))
       == 32'h0000_0000);
  endproperty
  a_wmask: assert property (p_wmask)
    else $error("masked output data bit changed");

  property p_rdclr;
    @(posedge sys_clk_in) disable iff (sys_rst_in)
    (rd_chg && $past(prev_valid)) |=> (chg_status == $past(change));
  endproperty
  a_rdclr: assert property (p_rdclr)
    else $error("change status not cleared on read");

  property p_irq;
    @(posedge sys_clk_in) disable iff (sys_rst_in)
    (|(change & irq_mask)) && !(|w_irq_dis) |=> irq_out;
  endproperty
  a_irq: assert property (p_irq)
    else $error("unmasked change gave no interrupt");

  property p_reserved;
    @(posedge sys_clk_in) disable iff (sys_rst_in)
    (reg_rd_in && reg_addr_in >= 8'h7C && reg_addr_in <= 8'h9C) |=>
      (reg_rdata_out == 32'h0000_0000);
  endproperty
  a_reserved: assert property (p_reserved)
    else $error("reserved offset read nonzero");

  property p_sel;
    @(posedge sys_clk_in) disable iff (sys_rst_in)
    (|w_sel_b) && !(|w_sel_a) |=>
      ((sel_status & $past(w_sel_b)) == $past(w_sel_b));
  endproperty
  a_sel: assert property (p_sel)
    else $error("peripheral B select did not set status");

  property p_sel_a;
    @(posedge sys_clk_in) disable iff (sys_rst_in)
    (|w_sel_a) |=> ((sel_status & $past(w_sel_a)) == 32'h0000_0000);
  endproperty
  a_sel_a: assert property (p_sel_a)
    else $error("peripheral A select did not clear status");

  property p_own_en;
    @(posedge sys_clk_in) disable iff (sys_rst_in)
    (|w_own_en) |=> ((own_status & $past(w_own_en)) == $past(w_own_en));
  endproperty
  a_own_en: assert property (p_own_en)
    else $error("ownership enable did not take line");

  property p_flt_dis;
    @(posedge sys_clk_in) disable iff (sys_rst_in)
    (|w_flt_dis) |=> ((flt_status & $past(w_flt_dis)) == 32'h0000_0000);
  endproperty
  a_flt_dis: assert property (p_flt_dis)
    else $error("filter disable did not clear status");

  property p_md_en;
    @(posedge sys_clk_in) disable iff (sys_rst_in)
    (|w_md_en) |=> ((md_status & $past(w_md_en)) == $past(w_md_en));
  endproperty
  a_md_en: assert property (p_md_en)
    else $error("open drain enable did not set status");

  property p_pu_dis;
    @(posedge sys_clk_in) disable iff (sys_rst_in)
    (|w_pu_dis) |=> ((pu_status & $past(w_pu_dis)) == 32'h0000_0000);
  endproperty
  a_pu_dis: assert property (p_pu_dis)
    else $error("pull-up disable did not clear status");

  property p_wm_en;
    @(posedge sys_clk_in) disable iff (sys_rst_in)
    (|w_wm_en) |=> ((wm_status & $past(w_wm_en)) == $past(w_wm_en));
  endproperty
  a_wm_en: assert property (p_wm_en)
    else $error("write mask enable did not set status");

  property p_irq_dis;
    @(posedge sys_clk_in) disable iff (sys_rst_in)
    (|w_irq_dis) |=> ((irq_mask & $past(w_irq_dis)) == 32'h0000_0000);
  endproperty
  a_irq_dis: assert property (p_irq_dis)
    else $error("interrupt disable did not clear mask");

  property p_chg_set;
    @(posedge sys_clk_in) disable iff (sys_rst_in)
    (|change) |=> ((chg_status & $past(change)) == $past(change));
  endproperty
  a_chg_set: assert property (p_chg_set)
    else $error("line change not recorded");

  property p_rd_window;
    @(posedge sys_clk_in) disable iff (sys_rst_in)
    !$past(reg_rd_in) |-> (reg_rdata_out == 32'h0000_0000);
  endproperty
  a_rd_window: assert property (p_rd_window)
    else $error("read data outside its cycle");

  property p_od_drain;
    @(posedge sys_clk_in) disable iff (sys_rst_in)
    ((pad_oe_out & pad_out & $past(md_status)) == 32'h0000_0000);
  endproperty
  a_od_drain: assert property (p_od_drain)
    else $error("open drain line driven high");

  property p_pin_level;
    @(posedge sys_clk_in) disable iff (sys_rst_in)
    ($past(flt_status) == 32'h0000_0000) |->
      (pin_level == ($past(pin_sample) & IMPL_LINES));
  endproperty
  a_pin_level: assert property (p_pin_level)
    else $error("pin level does not follow sampled lines");

  c_irq: cover property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    $rose(irq_out));
  c_rdclr: cover property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    rd_chg && (|chg_status));
  c_ods: cover property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    w_ods_hit && (|wm_status));
  c_release: cover property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    |w_own_dis);
  c_drain: cover property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    |(md_status & pad_oe_out));

endmodule : parallel_line_controller

// >>> tb/pad_partner.sv
// Pad model: resolves each line level from controller drive and outside level
module pad_partner
(
  input wire logic [31:0] drive_in, // Level from the controller
  input wire logic [31:0] oe_in, // Driver enable from the controller
  input wire logic [31:0] ext_in, // Level driven by outside devices
  output logic [31:0] line_out // Resolved line level
);
  timeunit 1ns;
  timeprecision 1ps;
  // Controller wins where it drives, outside devices hold the rest
  assign line_out = (drive_in & oe_in) | (ext_in & ~oe_in);
endmodule : pad_partner

// >>> tb/testbench.sv
// Testbench: register file, pad drive, pin sampling and change interrupt
module testbench;
  import pl_ctrl_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] IMPL = 32'h0FFF_FFFF;
  localparam logic [31:0] MUXED = 32'h00FF_FFFF;
  localparam logic [7:0] SET_T [9] = '{8'h00, 8'h10, 8'h20, 8'h30, 8'h40,
    8'h50, 8'h64, 8'h74, 8'hA0};
  localparam logic [7:0] CLR_T [9] = '{8'h04, 8'h14, 8'h24, 8'h34, 8'h44,
    8'h54, 8'h60, 8'h70, 8'hA4};
  localparam logic [7:0] ST_T [9] = '{8'h08, 8'h18, 8'h28, 8'h38, 8'h48,
    8'h58, 8'h68, 8'h78, 8'hA8};
  localparam logic [7:0] RSV_T [11] = '{8'h0C, 8'h1C, 8'h2C, 8'h5C, 8'h6C,
    8'h7C, 8'h8C, 8'h9C, 8'hAC, 8'h00, 8'h44};
  logic sys_clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  reg_req_t req = '0;
  logic [31:0] rdata, pad_in, pad_out, pad_oe, pad_pu, ext = 32'h0;
  logic [31:0] pa_out = 32'h0, pa_oe = 32'h0, pb_out = 32'h0, pb_oe = 32'h0;
  logic irq;
  logic [31:0] ex [9];
  logic [31:0] v, c, chg, got, drain;
  integer seed = 32'h566fa01c;
  integer bad_count = 0;
  integer check_count = 0;
  integer cyc = 0;
  parallel_line_controller #(.IMPL_LINES(IMPL), .MUXED_LINES(MUXED)) dut_u (
    .sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in),
    .reg_addr_in(req.addr), .reg_wdata_in(req.wdata), .reg_wr_in(req.wr),
    .reg_rd_in(req.rd), .reg_rdata_out(rdata), .pad_in(pad_in),
    .pad_out(pad_out), .pad_oe_out(pad_oe), .pad_pullup_out(pad_pu),
    .periph_a_out_in(pa_out), .periph_a_oe_in(pa_oe),
    .periph_b_out_in(pb_out), .periph_b_oe_in(pb_oe), .irq_out(irq));
  pad_partner pads_u (.drive_in(pad_out), .oe_in(pad_oe), .ext_in(ext),
    .line_out(pad_in));
  // ************************************************************
  // Clock, timeout and bus tasks
  // ************************************************************
  initial
  begin
    forever #2 sys_clk_in = ~sys_clk_in;
  end
  always @(posedge sys_clk_in)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      bad_count++;
      end_of_test();
    end
  end
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : end_of_test
  task automatic chk(input logic [31:0] g, input logic [31:0] e,
    input string what);
    check_count++;
    if (g !== e)
    begin
      bad_count++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, g, e);
    end
  endtask : chk
  // Expected pad level with released lines on peripheral A or B
  function automatic logic [31:0] exp_out(input logic [31:0] rel,
    input logic [31:0] selb);
    logic [31:0] own;
    own = ~(rel & MUXED);
    exp_out = (own & ex[3]) | (~own & selb & pb_out)
      | (~own & ~selb & pa_out);
    exp_out = exp_out & IMPL;
  endfunction : exp_out
  // Expected driver enable; open drain lines never drive a one
  function automatic logic [31:0] exp_oe(input logic [31:0] rel,
    input logic [31:0] selb, input logic [31:0] md);
    logic [31:0] own;
    own = ~(rel & MUXED);
    exp_oe = (own & 32'h0000_00FF) | (~own & selb & pb_oe)
      | (~own & ~selb & pa_oe);
    exp_oe = exp_oe & ~(md & exp_out(rel, selb)) & IMPL;
  endfunction : exp_oe
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk_in);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge sys_clk_in);
    req.wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge sys_clk_in);
    req.addr <= a;
    req.rd <= 1'b1;
    @(posedge sys_clk_in);
    req.rd <= 1'b0;
    #1 d = rdata;
  endtask : rd
  // ************************************************************
  // Main sequence
  // ************************************************************
  initial
  begin
    ex = '{default: 32'h0};
    ex[0] = IMPL;
    pa_out <= $random(seed);
    pa_oe <= $random(seed);
    pb_out <= $random(seed);
    pb_oe <= $random(seed);
    repeat (3) @(posedge sys_clk_in);
    sys_rst_in <= 1'b0;
    // Writes to reserved and read-only places leave reset state intact
    foreach (RSV_T[i]) wr(RSV_T[i], $random(seed));
    foreach (ST_T[i]) wr(ST_T[i], $random(seed));
    foreach (RSV_T[i])
    begin
      rd(RSV_T[i], got);
      chk(got, 32'h0, "reserved or write-only read");
    end
    foreach (ST_T[i])
    begin
      rd(ST_T[i], got);
      chk(got, ex[i], "reset value");
    end
    $display("test reset_and_reserved done");
    repeat (3)
    begin
      foreach (ST_T[i])
      begin
        v = $random(seed);
        c = $random(seed);
        wr(SET_T[i], v);
        wr(CLR_T[i], c);
        ex[i] = ((ex[i] | v) & ~(c & ((i == 0) ? MUXED : 32'hFFFF_FFFF)))
          & IMPL;
        rd(ST_T[i], got);
        chk(got, ex[i], "set and clear");
      end
      chk(pad_pu & IMPL, ex[6], "pull-up drive");
      v = $random(seed);
      wr(8'h38, v);
      ex[3] = ((ex[3] & ~ex[8]) | (v & ex[8])) & IMPL;
      rd(8'h38, got);
      chk(got, ex[3], "masked direct write");
    end
    $display("test set_clear_groups done");
    repeat (4)
    begin
      wr(8'h00, 32'hFFFF_FFFF);
      wr(8'h54, 32'hFFFF_FFFF);
      wr(8'h14, 32'hFFFF_FFFF);
      wr(8'h10, 32'h0000_00FF);
      v = $random(seed);
      c = $random(seed);
      wr(8'h30, v);
      wr(8'h34, c);
      ex[3] = (ex[3] | v) & ~c & IMPL;
      ext <= $random(seed);
      repeat (8) @(posedge sys_clk_in);
      rd(8'h38, got);
      chk(got, ex[3], "set and clear data");
      chk(pad_out, ex[3], "owned line drive");
      rd(8'h4C, got);
      chk(pad_oe & IMPL, 32'h0000_00FF, "driver enable");
      rd(8'h3C, got);
      v = ((ext & ~32'hFF) | (ex[3] & 32'hFF)) & IMPL;
      chk(got, v, "pin level");
      v = $random(seed);
      wr(8'h40, v);
      wr(8'h44, ~v);
      v = v & IMPL;
      c = $random(seed);
      chg = (ext ^ c) & ~32'hFF & IMPL;
      @(posedge sys_clk_in);
      ext <= c;
      repeat (8) @(posedge sys_clk_in);
      #1 chk({31'h0, irq}, {31'h0, |(chg & v)}, "irq level");
      rd(8'h4C, got);
      chk(got, chg, "change status");
      chk({31'h0, irq}, 32'h0, "irq after clear");
      rd(8'h4C, got);
      chk(got, 32'h0, "change status cleared");
    end
    $display("test pads_and_changes done");
    repeat (4)
    begin
      @(posedge sys_clk_in);
      pa_out <= $random(seed);
      pa_oe <= $random(seed);
      pb_out <= $random(seed);
      pb_oe <= $random(seed);
      v = $random(seed);
      c = $random(seed);
      drain = $random(seed);
      wr(8'h00, 32'hFFFF_FFFF);
      wr(8'h04, v);
      wr(8'h74, c);
      wr(8'h70, ~c);
      wr(8'h50, drain);
      wr(8'h54, ~drain);
      repeat (2) @(posedge sys_clk_in);
      #1 chk(pad_out, exp_out(v, c), "peripheral drive");
      chk(pad_oe, exp_oe(v, c, drain), "open drain enable");
      rd(8'h08, got);
      chk(got, ~(v & MUXED) & IMPL, "ownership status");
      rd(8'h78, got);
      chk(got, c & IMPL, "select status");
    end
    $display("test periph_and_drain done");
    end_of_test();
  end
endmodule : testbench
